//--- src/bts_pkg.sv
`default_nettype none
package bts_pkg;
   localparam int CLK_MHZ = 125;
   localparam int SETTLE_NS = 10000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int DEGLITCH_US = 10;
   localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
   localparam int PERSIST_US = 1000;
   localparam int PERSIST_CYC = PERSIST_US * CLK_MHZ;
   localparam int SLOW_DIV = 1250;
   localparam int PIN_DG_CYC = 16;
   localparam int I2C_DG_CYC = 64;
   localparam int NPIN = 4;
   localparam int CW = 24;
   localparam logic [2:0] MODE_PP = 3'h0;
   localparam logic [2:0] MODE_WEAK = 3'h1;
   localparam logic [2:0] MODE_OD = 3'h2;
   localparam logic [2:0] MODE_IN = 3'h3;
   localparam logic [2:0] MODE_ADC = 3'h4;
   localparam logic [1:0] MAP_TYPEC = 2'h0;
   localparam logic [1:0] MAP_PD = 2'h1;
   localparam logic [1:0] MAP_APP = 2'h2;
   localparam logic [1:0] MAP_FW = 2'h3;
   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_CLKON = 4'h1,
      ST_REGS = 4'h2,
      ST_TRIM = 4'h3,
      ST_SETTLE = 4'h4,
      ST_ADDR = 4'h5,
      ST_DEADCHK = 4'h6,
      ST_PATH = 4'h7,
      ST_PERSIST = 4'h8,
      ST_THERM = 4'h9,
      ST_PERIPH = 4'hA,
      ST_RUN = 4'hB
   } bts_state_type;
endpackage
`default_nettype wire

//--- src/bts_sequencer.sv
`default_nettype none
module bts_sequencer
   import bts_pkg::*;
#(
   parameter int PERSIST_COUNT = bts_pkg::PERSIST_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // supply monitors and straps (asynchronous)
   input wire logic REG3V3_GOOD,
   input wire logic SYS3V3_GOOD,
   input wire logic VBUS_GOOD,
   input wire logic BUS_POWER_SELECT_PIN,
   input wire logic [1:0] DEBUG_CONTROL_PINS,
   input wire logic [2:0] ADDR_STRAP,
   input wire logic [6:0] OTP_ADDR_BASE,
   // thermal comparators (asynchronous)
   input wire logic DIE_HOT,
   input wire logic DIE_COOL,
   input wire logic PATH_HOT,
   input wire logic PATH_COOL,
   // software clear strobes
   input wire logic CLR_DEADBAT,
   input wire logic CLR_DIE_EVT,
   input wire logic CLR_PATH_EVT,
   // general pins
   input wire logic [NPIN*3-1:0] PIN_MODE,
   input wire logic [NPIN*2-1:0] PIN_MAP,
   input wire logic [NPIN-1:0] PIN_FW_OUT,
   input wire logic [NPIN-1:0] PIN_IN,
   input wire logic [2:0] EVT_TYPEC,
   input wire logic [2:0] EVT_PD,
   input wire logic [2:0] EVT_APP,
   input wire logic PORT_MON_DIGITAL,
   // core and power control
   output logic CORE_RST,
   output logic CORE_CLK_EN,
   output logic RESET_IRQ,
   output logic [6:0] I2C_ADDR1,
   output logic [6:0] I2C_ADDR2,
   output logic HOST_IF_LIMITED,
   output logic PATH_CFG_VALID,
   output logic PATH_SEL,
   output logic CLK48_EN,
   output logic CLK_SLOW_TICK,
   output logic THERM_EN,
   output logic PERIPH_EN,
   output logic CORE_HALT,
   output logic PORT_SWITCH_OFF,
   output logic DIE_IRQ,
   output logic PATH_IRQ,
   // status
   output logic [3:0] BOOT_STAGE,
   output logic DEADBAT_FLAG,
   output logic DIE_EVT_FLAG,
   output logic PATH_EVT_FLAG,
   // pin drivers
   output logic [NPIN-1:0] PIN_OUT,
   output logic [NPIN-1:0] PIN_OE_N,
   output logic [NPIN-1:0] PIN_WEAK,
   output logic [NPIN-1:0] PIN_ADC_SEL,
   output logic [NPIN-1:0] PIN_DG,
   output logic PORT_MON_BUF_EN
);
   // double-flop sync for all async inputs; nothing reads the first stage
   // word: supplies and select, debug pins, strap, otp, four comparators, pins
   localparam int NS = 20 + NPIN;
   logic [NS-1:0] s1, s2, next_s1;
   logic reg_ok, sys_ok, vbus_ok, bps, die_hot, die_cool, path_hot, path_cool;
   logic [1:0] dbg;
   logic [2:0] strap;
   logic [6:0] otp;
   logic [NPIN-1:0] pin_s;
   always_comb begin
      next_s1 = {REG3V3_GOOD, SYS3V3_GOOD, VBUS_GOOD, BUS_POWER_SELECT_PIN,
                 DEBUG_CONTROL_PINS, ADDR_STRAP, OTP_ADDR_BASE, DIE_HOT, DIE_COOL,
                 PATH_HOT, PATH_COOL, PIN_IN};
   end
   always_ff @(posedge CLK) begin
      s1 <= next_s1;
      s2 <= s1;
   end
   assign {reg_ok, sys_ok, vbus_ok, bps, dbg, strap, otp, die_hot, die_cool,
           path_hot, path_cool, pin_s} = s2;

   // boot sequencer state
   bts_state_type st, next_st;
   logic [CW-1:0] cnt, next_cnt;
   logic [6:0] a1, a2, next_a1, next_a2;
   logic dead, next_dead, psel, next_psel, pvalid, next_pvalid;
   logic [10:0] div, next_div;
   always_comb begin
      next_st = st;
      next_cnt = cnt + CW'(1);
      next_a1 = a1;
      next_a2 = a2;
      next_dead = dead;
      next_psel = psel;
      next_pvalid = pvalid;
      // slow tick divider free-runs from reset, whatever the boot stage
      next_div = (div == 11'(SLOW_DIV - 1)) ? 11'h000 : div + 11'h001;
      // clear first so that a detection in the same cycle wins
      if (CLR_DEADBAT) next_dead = 1'b0;
      unique case (st)
         ST_RESET: begin
            next_cnt = '0;
            if (reg_ok) next_st = ST_CLKON;
         end
         ST_CLKON: next_st = ST_REGS;
         ST_REGS: next_st = ST_TRIM;
         ST_TRIM: begin
            next_st = ST_SETTLE;
            next_cnt = '0;
         end
         ST_SETTLE: if (cnt == CW'(SETTLE_CYC - 1)) next_st = ST_ADDR;
         ST_ADDR: begin
            // one-shot capture; later strap changes are ignored
            next_a1 = otp ^ {2'h0, dbg, strap};
            next_a2 = (otp ^ {2'h0, dbg, strap}) + 7'h01;
            next_st = ST_DEADCHK;
         end
         ST_DEADCHK: begin
            if (!sys_ok && vbus_ok) begin
               next_dead = 1'b1;
               next_st = ST_PATH;
            end else begin
               next_st = ST_PERSIST;
            end
            next_cnt = '0;
         end
         ST_PATH: begin
            next_psel = bps;
            next_pvalid = 1'b1;
            next_st = ST_PERSIST;
            next_cnt = '0;
         end
         ST_PERSIST: begin
            // the count restarts only while neither the system nor the bus supply is valid
            if (!(vbus_ok || sys_ok)) next_cnt = '0;
            else if (cnt == CW'(PERSIST_COUNT - 1)) next_st = ST_THERM;
         end
         ST_THERM: next_st = ST_PERIPH;
         ST_PERIPH: next_st = ST_RUN;
         ST_RUN: next_cnt = cnt;
         default: next_st = ST_RESET;
      endcase
      // a regulator drop overrides every stage, halted ones included
      if (!reg_ok) next_st = ST_RESET;
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         st <= ST_RESET;
         cnt <= '0;
         a1 <= 7'h00;
         a2 <= 7'h00;
         dead <= 1'b0;
         psel <= 1'b0;
         pvalid <= 1'b0;
         div <= 11'h000;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         a1 <= next_a1;
         a2 <= next_a2;
         dead <= next_dead;
         psel <= next_psel;
         pvalid <= next_pvalid;
         div <= next_div;
      end
   end

   // thermal deglitch and latches; die state releases only on cool side
   logic [10:0] dcnt, pcnt, next_dcnt, next_pcnt;
   logic dtrip, ptrip, next_dtrip, next_ptrip, devt, pevt, next_devt, next_pevt;
   logic dirq, pirq, next_dirq, next_pirq;
   logic therm_on;
   assign therm_on = (st == ST_THERM) || (st == ST_PERIPH) || (st == ST_RUN);
   always_comb begin
      // any sample that is not hot restarts the count, so short blips never add up
      next_dcnt = (therm_on && die_hot && !dtrip) ? dcnt + 11'h001 : 11'h000;
      next_pcnt = (therm_on && path_hot && !ptrip) ? pcnt + 11'h001 : 11'h000;
      next_dtrip = dtrip;
      next_ptrip = ptrip;
      next_dirq = 1'b0;
      next_pirq = 1'b0;
      // clears come first; a trip in the same cycle sets the flag again
      next_devt = devt && !CLR_DIE_EVT;
      next_pevt = pevt && !CLR_PATH_EVT;
      if (dcnt == 11'(DEGLITCH_CYC - 1)) begin
         next_dtrip = 1'b1;
         next_dirq = 1'b1;
         next_devt = 1'b1;
      end
      if (dtrip && die_cool) next_dtrip = 1'b0;
      if (pcnt == 11'(DEGLITCH_CYC - 1)) begin
         next_ptrip = 1'b1;
         next_pirq = 1'b1;
         next_pevt = 1'b1;
      end
      if (ptrip && path_cool) next_ptrip = 1'b0;
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         dcnt <= 11'h000;
         pcnt <= 11'h000;
         dtrip <= 1'b0;
         ptrip <= 1'b0;
         dirq <= 1'b0;
         pirq <= 1'b0;
         devt <= 1'b0;
         pevt <= 1'b0;
      end else begin
         dcnt <= next_dcnt;
         pcnt <= next_pcnt;
         dtrip <= next_dtrip;
         ptrip <= next_ptrip;
         dirq <= next_dirq;
         pirq <= next_pirq;
         devt <= next_devt;
         pevt <= next_pevt;
      end
   end

   // general pins: mode decode, event mapping, input deglitch
   logic [NPIN-1:0] pdg, next_pdg, pout, next_pout;
   logic [5:0] pc [NPIN];
   logic [5:0] next_pc [NPIN];
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : gp
         logic [2:0] md;
         logic [1:0] mp;
         logic [5:0] lim;
         logic src;
         assign md = PIN_MODE[g*3 +: 3];
         assign mp = PIN_MAP[g*2 +: 2];
         // the last two pins use the longer I2C deglitch filter
         assign lim = (g >= NPIN - 2) ? 6'(I2C_DG_CYC - 1) : 6'(PIN_DG_CYC - 1);
         always_comb begin
            unique case (mp)
               MAP_TYPEC: src = EVT_TYPEC[g % 3];
               MAP_PD: src = EVT_PD[g % 3];
               MAP_APP: src = EVT_APP[g % 3];
               MAP_FW: src = PIN_FW_OUT[g];
            endcase
            next_pout[g] = (md == MODE_OD) ? 1'b0 : src;
            // a new level must stand for lim+1 cycles before it is taken
            next_pc[g] = (pin_s[g] == pdg[g]) ? 6'h00 : pc[g] + 6'h01;
            next_pdg[g] = pdg[g];
            if (pc[g] == lim) begin
               next_pdg[g] = pin_s[g];
               next_pc[g] = 6'h00;
            end
         end
         always_ff @(posedge CLK) begin
            if (SRST) begin
               pc[g] <= 6'h00;
               pdg[g] <= 1'b0;
               pout[g] <= 1'b0;
            end else begin
               pc[g] <= next_pc[g];
               pdg[g] <= next_pdg[g];
               pout[g] <= next_pout[g];
            end
         end
         // open drain drives only when pulling low; input and adc modes float
         assign PIN_OE_N[g] = !(PERIPH_EN && ((md == MODE_PP) || (md == MODE_WEAK) ||
                              ((md == MODE_OD) && !src)));
         assign PIN_WEAK[g] = (md == MODE_WEAK);
         assign PIN_ADC_SEL[g] = (md == MODE_ADC);
      end
   endgenerate

   // outputs
   // a die trip gates core clock and peripherals; supervision keeps running
   assign CORE_RST = (st == ST_RESET);
   assign CORE_CLK_EN = (st != ST_RESET) && !dtrip;
   assign RESET_IRQ = (st == ST_CLKON);
   assign I2C_ADDR1 = a1;
   assign I2C_ADDR2 = a2;
   assign HOST_IF_LIMITED = (st > ST_ADDR) && (st != ST_RUN);
   assign PATH_CFG_VALID = pvalid;
   assign PATH_SEL = psel;
   assign CLK48_EN = (st >= ST_PERSIST) && !dtrip;
   assign CLK_SLOW_TICK = (div == 11'h000);
   assign THERM_EN = therm_on;
   assign PERIPH_EN = ((st == ST_PERIPH) || (st == ST_RUN)) && !dtrip;
   assign CORE_HALT = dtrip;
   assign PORT_SWITCH_OFF = ptrip || dtrip;
   assign DIE_IRQ = dirq;
   assign PATH_IRQ = pirq;
   assign BOOT_STAGE = st;
   assign DEADBAT_FLAG = dead;
   assign DIE_EVT_FLAG = devt;
   assign PATH_EVT_FLAG = pevt;
   assign PIN_OUT = pout;
   assign PIN_DG = pdg;
   assign PORT_MON_BUF_EN = PORT_MON_DIGITAL;
endmodule
`default_nettype wire

//--- testbench/bts_properties.sv
`default_nettype none
module bts_properties
   import bts_pkg::*;
(
   // clock, reset, regulator valid and raw thermal levels
   input wire logic CLK,
   input wire logic SRST,
   input wire logic REG3V3_GOOD,
   input wire logic DIE_HOT,
   input wire logic PATH_HOT,
   // boot and thermal outputs
   input wire logic CORE_RST,
   input wire logic CORE_CLK_EN,
   input wire logic RESET_IRQ,
   input wire logic HOST_IF_LIMITED,
   input wire logic THERM_EN,
   input wire logic PERIPH_EN,
   input wire logic CORE_HALT,
   input wire logic PORT_SWITCH_OFF,
   input wire logic DIE_IRQ,
   input wire logic DIE_EVT_FLAG,
   input wire logic [3:0] BOOT_STAGE,
   input wire logic [6:0] I2C_ADDR1,
   input wire logic [6:0] I2C_ADDR2
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   int die_cnt, path_cnt;
   // raw hot time: a trip sooner than the deglitch span is a fault
   always_ff @(posedge CLK) begin
      die_cnt <= DIE_HOT ? die_cnt + 1 : 0;
      path_cnt <= PATH_HOT ? path_cnt + 1 : 0;
   end
   sequence s_boot_start;
      BOOT_STAGE == ST_RESET ##1 BOOT_STAGE == ST_CLKON;
   endsequence
   // a regulator drop reaches the stage register through the two sync flops
   AST_CORE_RST: assert property (!REG3V3_GOOD |->
      ##3 (CORE_RST && BOOT_STAGE == ST_RESET))
      else $error("core reset not held while regulator low");
   AST_RESET_IRQ: assert property (s_boot_start |->
      (RESET_IRQ && CORE_CLK_EN) ##1 !RESET_IRQ) else $error("bad boot start pulse");
   AST_ADDR_PAIR: assert property (HOST_IF_LIMITED && BOOT_STAGE != ST_ADDR
      |-> I2C_ADDR2 == I2C_ADDR1 + 7'h1) else $error("second address not first plus one");
   AST_ADDR_ONCE: assert property (HOST_IF_LIMITED && $past(HOST_IF_LIMITED)
      && $past(BOOT_STAGE) != ST_ADDR |-> $stable(I2C_ADDR1)) else $error("address moved");
   AST_PERIPH_LAST: assert property ($rose(PERIPH_EN) |-> THERM_EN && $past(THERM_EN))
      else $error("peripherals before thermal protection");
   AST_DIE_DEGLITCH: assert property ($rose(CORE_HALT) |-> die_cnt >= DEGLITCH_CYC)
      else $error("die trip too early");
   AST_PATH_DEGLITCH: assert property ($rose(PORT_SWITCH_OFF) |->
      path_cnt >= DEGLITCH_CYC || die_cnt >= DEGLITCH_CYC) else $error("switch off too early");
   AST_DIE_IRQ: assert property (DIE_IRQ |=> !DIE_IRQ && DIE_EVT_FLAG)
      else $error("die interrupt not a pulse with flag");
   AST_HALT_HOLD: assert property (CORE_HALT && DIE_HOT |=> CORE_HALT)
      else $error("halt released while hot");
endmodule
`default_nettype wire

//--- testbench/bts_env_model.sv
`default_nettype none
module bts_env_model #(
   parameter int die_trip_temperature = 150,
   parameter int die_trip_hysteresis = 20,
   parameter int powerpath_trip_temperature = 140,
   parameter int powerpath_trip_hysteresis = 15,
   parameter int ramp = 30
) (
   // clock, supply switches (regulator, system, bus) and temperatures
   input wire logic clk,
   input wire logic [2:0] sup_on,
   input var int die_temp,
   input var int path_temp,
   // supply valid levels and comparators
   output logic [2:0] sup_good,
   output logic die_hot,
   output logic die_cool,
   output logic path_hot,
   output logic path_cool
);
   timeunit 1ns;
   timeprecision 1ps;
   int age [3];
   // supplies read valid only after a ramp, so the block meets a slow answer
   always_ff @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         age[i] <= sup_on[i] ? age[i] + 1 : 0;
      end
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         sup_good[i] = sup_on[i] && age[i] >= ramp;
      end
   end
   // inside the hysteresis gap neither comparator is active
   assign die_hot = die_temp > die_trip_temperature;
   assign die_cool = die_temp < die_trip_temperature - die_trip_hysteresis;
   assign path_hot = path_temp > powerpath_trip_temperature;
   assign path_cool = path_temp < powerpath_trip_temperature - powerpath_trip_hysteresis;
endmodule
`default_nettype wire

//--- testbench/bts_sequencer_tb_top.sv
`default_nettype none
module bts_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bts_pkg::*;
   localparam int PC = 20;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic BUS_POWER_SELECT_PIN, CLR_DEADBAT, CLR_DIE_EVT, CLR_PATH_EVT, PORT_MON_DIGITAL;
   logic [1:0] DEBUG_CONTROL_PINS;
   logic [2:0] ADDR_STRAP, EVT_TYPEC, EVT_PD, EVT_APP, sup_on;
   logic [6:0] OTP_ADDR_BASE, I2C_ADDR1, I2C_ADDR2;
   logic [11:0] PIN_MODE;
   logic [7:0] PIN_MAP;
   logic [3:0] PIN_FW_OUT, PIN_IN, BOOT_STAGE, PIN_OUT, PIN_OE_N, PIN_WEAK, PIN_ADC_SEL, PIN_DG;
   logic CORE_RST, CORE_CLK_EN, RESET_IRQ, HOST_IF_LIMITED, PATH_CFG_VALID, PATH_SEL, CLK48_EN;
   logic CLK_SLOW_TICK, THERM_EN, PERIPH_EN, CORE_HALT, PORT_SWITCH_OFF, DIE_IRQ, PATH_IRQ;
   logic DEADBAT_FLAG, DIE_EVT_FLAG, PATH_EVT_FLAG, PORT_MON_BUF_EN;
   wire logic REG3V3_GOOD, SYS3V3_GOOD, VBUS_GOOD, DIE_HOT, DIE_COOL, PATH_HOT, PATH_COOL;
   int die_temp, path_temp, failures, n_checks;
   // 125 MHz
   always #4 CLK = ~CLK;
   bts_env_model u_env (.clk(CLK), .sup_on(sup_on), .die_temp(die_temp), .path_temp(path_temp),
      .sup_good({REG3V3_GOOD, SYS3V3_GOOD, VBUS_GOOD}), .die_hot(DIE_HOT), .die_cool(DIE_COOL),
      .path_hot(PATH_HOT), .path_cool(PATH_COOL));
   // short persistence count keeps the run brief
   bts_sequencer #(.PERSIST_COUNT(PC)) DUT (.*);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge CLK);
   endtask
   // sampled at falling edges so one-cycle stages are not missed
   task automatic wait_stage(input logic [3:0] st, input int lim);
      for (int i = 0; i < lim && BOOT_STAGE !== st; i++) begin
         @(negedge CLK);
      end
      check(BOOT_STAGE, st);
   endtask
   task automatic wait_irq(input logic die);
      for (int i = 0; i < DEGLITCH_CYC + 20 && (die ? DIE_IRQ : PATH_IRQ) !== 1'b1; i++) begin
         @(negedge CLK);
      end
      check(die ? DIE_IRQ : PATH_IRQ, 1'b1);
   endtask
   task automatic boot(input logic dead, input logic sel);
      logic [6:0] exp;
      @(posedge CLK);
      sup_on <= {1'b1, ~dead, 1'b1};
      BUS_POWER_SELECT_PIN <= sel;
      wait_stage(ST_CLKON, 100);
      exp = OTP_ADDR_BASE ^ {2'b00, DEBUG_CONTROL_PINS, ADDR_STRAP};
      check({RESET_IRQ, CORE_CLK_EN, CORE_RST}, 3'h6);
      wait_stage(ST_PERSIST, SETTLE_CYC + 50);
      check({HOST_IF_LIMITED, CLK48_EN, THERM_EN}, 3'h6);
      check({PATH_CFG_VALID, DEADBAT_FLAG, PATH_SEL & dead}, {dead, dead, sel & dead});
      // straps move after capture and must not be seen
      @(posedge CLK);
      ADDR_STRAP <= ~ADDR_STRAP;
      DEBUG_CONTROL_PINS <= ~DEBUG_CONTROL_PINS;
      BUS_POWER_SELECT_PIN <= ~sel;
      wait_stage(ST_RUN, PC + 50);
      check({THERM_EN, PERIPH_EN, PATH_SEL & dead}, {2'h3, sel & dead});
      check({I2C_ADDR1, I2C_ADDR2}, {exp, exp + 7'h1});
      $display("boot scenario done");
   endtask
   task automatic pins();
      @(posedge CLK);
      PIN_MODE <= {MODE_WEAK, MODE_PP, MODE_PP, MODE_PP};
      PIN_MAP <= {4{MAP_FW}};
      PIN_FW_OUT <= 4'hA;
      PORT_MON_DIGITAL <= 1'b1;
      tick(4);
      check({PIN_OE_N, PIN_WEAK, PIN_OUT, 3'h0, PORT_MON_BUF_EN}, 16'h08A1);
      @(posedge CLK);
      PIN_MODE <= {4{MODE_IN}};
      PORT_MON_DIGITAL <= 1'b0;
      tick(4);
      check({PIN_OE_N, PORT_MON_BUF_EN}, 5'h1E);
      // open drain, adc and event maps; input filter is longer on the top two pins
      @(posedge CLK);
      PIN_MODE <= {MODE_ADC, MODE_OD, MODE_OD, MODE_PP};
      PIN_MAP <= {MAP_FW, MAP_APP, MAP_PD, MAP_TYPEC};
      {EVT_TYPEC, EVT_PD, EVT_APP} <= {3'h1, 3'h0, 3'h4};
      PIN_IN <= 4'h5;
      tick(30);
      check({PIN_OE_N, PIN_OUT, PIN_ADC_SEL, PIN_WEAK}, 16'hC980);
      check(PIN_DG, 4'h9);
      tick(50);
      check(PIN_DG, 4'h5);
      $display("pin scenario done");
   endtask
   // the slow tick is a single-cycle enable, one per divider period
   task automatic slow_clock();
      int n;
      n = 0;
      repeat (2 * SLOW_DIV) begin
         @(negedge CLK);
         n += int'(CLK_SLOW_TICK);
      end
      check(16'(n), 16'h0002);
      $display("slow clock scenario done");
   endtask
   task automatic thermal();
      // a hot blip shorter than the deglitch span is ignored
      @(posedge CLK);
      die_temp <= 200;
      tick(DEGLITCH_CYC / 2);
      @(posedge CLK);
      die_temp <= 140;
      tick(20);
      check(CORE_HALT, 1'b0);
      @(posedge CLK);
      die_temp <= 200;
      wait_irq(1'b1);
      tick(1);
      check({CORE_HALT, PORT_SWITCH_OFF, DIE_EVT_FLAG}, 3'h7);
      check({CORE_CLK_EN, PERIPH_EN, CLK48_EN}, 3'h0);
      @(posedge CLK);
      die_temp <= 140;
      tick(20);
      check(CORE_HALT, 1'b1);
      @(posedge CLK);
      die_temp <= 25;
      CLR_DIE_EVT <= 1'b1;
      path_temp <= 200;
      @(posedge CLK);
      CLR_DIE_EVT <= 1'b0;
      wait_irq(1'b0);
      tick(1);
      check({CORE_HALT, DIE_EVT_FLAG, PORT_SWITCH_OFF, PATH_EVT_FLAG}, 4'h3);
      check({CORE_CLK_EN, PERIPH_EN}, 2'h3);
      $display("thermal scenario done");
   endtask
   // regulator drop mid-run, then a boot from bus power alone
   task automatic dead_battery();
      @(posedge CLK);
      sup_on <= 3'h0;
      path_temp <= 25;
      CLR_PATH_EVT <= 1'b1;
      OTP_ADDR_BASE <= 7'h7F;
      wait_stage(ST_RESET, 50);
      check(CORE_RST, 1'b1);
      @(posedge CLK);
      CLR_PATH_EVT <= 1'b0;
      boot(1'b1, 1'b1);
      @(posedge CLK);
      CLR_DEADBAT <= 1'b1;
      @(posedge CLK);
      CLR_DEADBAT <= 1'b0;
      tick(2);
      check({DEADBAT_FLAG, PATH_EVT_FLAG}, 2'h0);
      $display("dead battery scenario done");
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // the run needs about 8400 cycles; the watchdog allows 30000
   initial begin
      #(8 * 30000);
      failures++;
      summarize();
   end
   initial begin
      {BUS_POWER_SELECT_PIN, CLR_DEADBAT, CLR_DIE_EVT, CLR_PATH_EVT, PORT_MON_DIGITAL} = 5'h0;
      {EVT_TYPEC, EVT_PD, EVT_APP, sup_on} = 12'h0;
      {DEBUG_CONTROL_PINS, ADDR_STRAP, OTP_ADDR_BASE} = {2'h2, 3'h5, 7'h38};
      {PIN_MODE, PIN_MAP, PIN_FW_OUT, PIN_IN} = {{4{MODE_IN}}, 8'h00, 8'h5A};
      die_temp = 25;
      path_temp = 25;
      repeat (5) @(posedge CLK);
      SRST <= 1'b0;
      tick(5);
      check({CORE_RST, BOOT_STAGE}, {1'b1, ST_RESET});
      boot(1'b0, 1'b0);
      pins();
      slow_clock();
      thermal();
      dead_battery();
      summarize();
   end
endmodule
bind bts_sequencer bts_properties u_props (.*);
`default_nettype wire
